// ==== ft8_pkg.sv ====
// ****************************************
// constants of the four channel timer
// ****************************************
package ft8_pkg;

    localparam int          FT8_CH       = 4;
    localparam int          FT8_AW       = 6;
    localparam int          FT8_DW       = 8;
    localparam int          FT8_PRE_W    = 13;

    // register index inside a channel window: address = ch * 8 + index
    localparam logic [2:0]  REG_CTRL     = 3'h0;
    localparam logic [2:0]  REG_OUTC     = 3'h1;
    localparam logic [2:0]  REG_STAT     = 3'h2;
    localparam logic [2:0]  REG_CNT      = 3'h3;
    localparam logic [2:0]  REG_CORA     = 3'h4;
    localparam logic [2:0]  REG_CORB     = 3'h5;
    localparam logic [5:0]  ADDR_MSTOP   = 6'h20;

    // control register fields
    localparam int          CTRL_CKS_LSB = 0;
    localparam int          CTRL_CLR_LSB = 3;
    localparam int          CTRL_IEA     = 5;
    localparam int          CTRL_IEB     = 6;
    localparam int          CTRL_IEW     = 7;
    // output control fields
    localparam int          OUTC_A_LSB   = 0;
    localparam int          OUTC_B_LSB   = 2;
    localparam int          OUTC_ADTE    = 4;
    // status bits, write one to clear
    localparam int          STAT_MFA     = 0;
    localparam int          STAT_MFB     = 1;
    localparam int          STAT_WRAP    = 2;

    // reset values
    localparam logic [7:0]  RST_CTRL     = 8'h00;
    localparam logic [7:0]  RST_OUTC     = 8'h00;
    localparam logic [7:0]  RST_CNT      = 8'h00;
    localparam logic [7:0]  RST_COR      = 8'hFF;
    localparam logic        RST_MSTOP    = 1'b1;
    localparam logic [7:0]  CNT_TOP      = 8'hFF;

    // prescaler tap masks for the three internal divisions
    localparam logic [12:0] DIV8_MASK    = 13'h0007;
    localparam logic [12:0] DIV64_MASK   = 13'h003F;
    localparam logic [12:0] DIV8192_MASK = 13'h1FFF;

    typedef enum logic [2:0] {
        CKS_STOP    = 3'h0,
        CKS_DIV8    = 3'h1,
        CKS_DIV64   = 3'h2,
        CKS_DIV8192 = 3'h3,
        CKS_EXT_R   = 3'h4,
        CKS_EXT_F   = 3'h5,
        CKS_EXT_B   = 3'h6,
        CKS_CASC    = 3'h7
    } ft8_cks_type;

    typedef enum logic [1:0] {
        CLR_NONE = 2'h0,
        CLR_A    = 2'h1,
        CLR_B    = 2'h2,
        CLR_EXT  = 2'h3
    } ft8_clr_type;

    typedef enum logic [1:0] {
        OUT_KEEP   = 2'h0,
        OUT_LOW    = 2'h1,
        OUT_HIGH   = 2'h2,
        OUT_TOGGLE = 2'h3
    } ft8_out_type;

endpackage

// ==== ft8_pre_if.sv ====
`timescale 1ns/1ps
// ****************************************
// prescaler run control and tick pulses
// ****************************************
interface ft8_pre_if;
    logic run;
    logic tick_8;
    logic tick_64;
    logic tick_8192;
    modport ctl (output run, input tick_8, input tick_64, input tick_8192);
    modport pre (input run, output tick_8, output tick_64, output tick_8192);
endinterface

// ==== ft8_prescale.sv ====
`timescale 1ns/1ps
// ****************************************
// system clock prescaler
// ****************************************
module ft8_prescale
    import ft8_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    ft8_pre_if.pre    pre
);

    logic [FT8_PRE_W-1:0] div_ff;
    logic                 t8_ff;
    logic                 t64_ff;
    logic                 t8192_ff;

    // free divider, held while the timer sits in module stop
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_ff <= '0;
        end else if (pre.run) begin
            div_ff <= div_ff + 13'h0001;
        end
    end

    // one cycle tick at the end of each division period
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            t8_ff    <= 1'b0;
            t64_ff   <= 1'b0;
            t8192_ff <= 1'b0;
        end else begin
            t8_ff    <= pre.run && ((div_ff & DIV8_MASK) == DIV8_MASK);
            t64_ff   <= pre.run && ((div_ff & DIV64_MASK) == DIV64_MASK);
            t8192_ff <= pre.run && ((div_ff & DIV8192_MASK) == DIV8192_MASK);
        end
    end

    assign pre.tick_8    = t8_ff;
    assign pre.tick_64   = t64_ff;
    assign pre.tick_8192 = t8192_ff;

endmodule

// ==== ft8_timer.sv ====
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
// What this block does
// - four independent channels, each an 8-bit up-counter with compare constants A and B
// - count clock is one of three prescaler divisions or the external clock pin
// - counter cleared by match A, match B or external reset, as control selects
// - channel output level is set by the two compare matches, giving pulse or PWM
// - 16-bit mode: channel 0 upper byte, channel 1 lower byte
// - compare match count mode: channel 1 counts channel 0 match A events
// - three interrupt requests per channel from match A, match B and wrap flags
// - match A and B requests may start the transfer controller, wrap may not
// - fixed priority after reset: ch0 A highest down to ch3 wrap lowest
// - channel 0 match A can serve as the A/D conversion start trigger
// - after reset the timer halts in module stop, registers locked until exit
// - clear on match A: A sets period, B duty, pulses repeat by themselves
module ft8_timer
    import ft8_pkg::*;
(
    input  wire logic                CLK_IN,
    input  wire logic                RESETN_IN,
    input  wire logic [ft8_pkg::FT8_AW-1:0] ADDR_IN,
    input  wire logic [ft8_pkg::FT8_DW-1:0] WDATA_IN,
    input  wire logic                WR_IN,
    input  wire logic                RD_IN,
    output logic      [ft8_pkg::FT8_DW-1:0] RDATA_OUT,
    input  wire logic [ft8_pkg::FT8_CH-1:0] EXT_CLK_IN,
    input  wire logic [ft8_pkg::FT8_CH-1:0] EXT_RST_IN,
    output logic      [ft8_pkg::FT8_CH-1:0] TMR_OUT_OUT,
    output logic      [ft8_pkg::FT8_CH-1:0] MATCH_A_IRQ_OUT,
    output logic      [ft8_pkg::FT8_CH-1:0] MATCH_B_IRQ_OUT,
    output logic      [ft8_pkg::FT8_CH-1:0] WRAP_IRQ_OUT,
    output logic      [2*ft8_pkg::FT8_CH-1:0] XFER_REQ_OUT,
    output logic                     IRQ_ANY_OUT,
    output logic      [3:0]          IRQ_ID_OUT,
    output logic                     ADC_TRIG_OUT,
    output logic                     MSTOP_OUT
);

    // ****************************************
    // declarations
    // ****************************************
    logic                mstop_ff;
    logic [7:0]          rdata_ff;
    logic                adc_ff;
    logic [7:0]          ctrl_ff [FT8_CH];
    logic [7:0]          outc_ff [FT8_CH];
    logic [7:0]          cnt_ff  [FT8_CH];
    logic [7:0]          cora_ff [FT8_CH];
    logic [7:0]          corb_ff [FT8_CH];
    logic [FT8_CH-1:0]   mfa_ff;
    logic [FT8_CH-1:0]   mfb_ff;
    logic [FT8_CH-1:0]   wrap_ff;
    logic [FT8_CH-1:0]   out_ff;
    logic [FT8_CH-1:0]   eclk_s1_ff;
    logic [FT8_CH-1:0]   eclk_s2_ff;
    logic [FT8_CH-1:0]   eclk_s3_ff;
    logic [FT8_CH-1:0]   erst_s1_ff;
    logic [FT8_CH-1:0]   erst_s2_ff;
    logic [FT8_CH-1:0]   erst_s3_ff;
    logic [FT8_CH-1:0]   base_tick;
    logic [FT8_CH-1:0]   tick;
    logic [FT8_CH-1:0]   eq_a;
    logic [FT8_CH-1:0]   eq_b;
    logic [FT8_CH-1:0]   at_top;
    logic [FT8_CH-1:0]   match_a_ev;
    logic [FT8_CH-1:0]   match_b_ev;
    logic [FT8_CH-1:0]   clr_ev;
    logic [FT8_CH-1:0]   wrap_ev;
    logic [FT8_CH-1:0]   irq_a;
    logic [FT8_CH-1:0]   irq_b;
    logic [FT8_CH-1:0]   irq_w;
    logic                acc_ok;
    logic [1:0]          acc_ch;
    logic [2:0]          acc_reg;
    logic [7:0]          nxt_rdata;
    logic [3:0]          nxt_id;
    logic                nxt_any;

    ft8_pre_if pre_bus ();

    // ****************************************
    // prescaler
    // ****************************************
    assign pre_bus.run = !mstop_ff;

    ft8_prescale u_pre (
        .clk_in   (CLK_IN),
        .rst_n_in (RESETN_IN),
        .pre      (pre_bus)
    );

    // ****************************************
    // register access decode
    // ****************************************
    // channel windows open only after module stop is left
    assign acc_ok  = !mstop_ff && (ADDR_IN[5] == 1'b0);
    assign acc_ch  = ADDR_IN[4:3];
    assign acc_reg = ADDR_IN[2:0];

    // module stop bit, always reachable, set out of reset
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            mstop_ff <= RST_MSTOP;
        end else if (WR_IN && (ADDR_IN == ADDR_MSTOP)) begin
            mstop_ff <= WDATA_IN[0];
        end
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    // two stages, third stage only for edge finding
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            eclk_s1_ff <= '0;
            eclk_s2_ff <= '0;
            eclk_s3_ff <= '0;
            erst_s1_ff <= '0;
            erst_s2_ff <= '0;
            erst_s3_ff <= '0;
        end else begin
            eclk_s1_ff <= EXT_CLK_IN;
            eclk_s2_ff <= eclk_s1_ff;
            eclk_s3_ff <= eclk_s2_ff;
            erst_s1_ff <= EXT_RST_IN;
            erst_s2_ff <= erst_s1_ff;
            erst_s3_ff <= erst_s2_ff;
        end
    end

    // ****************************************
    // count clock selection
    // ****************************************
    always_comb begin
        base_tick = '0;
        for (int i = 0; i < FT8_CH; i++) begin
            case (ft8_cks_type'(ctrl_ff[i][CTRL_CKS_LSB +: 3]))
                CKS_DIV8:    base_tick[i] = pre_bus.tick_8;
                CKS_DIV64:   base_tick[i] = pre_bus.tick_64;
                CKS_DIV8192: base_tick[i] = pre_bus.tick_8192;
                CKS_EXT_R:   base_tick[i] = eclk_s2_ff[i] & ~eclk_s3_ff[i];
                CKS_EXT_F:   base_tick[i] = ~eclk_s2_ff[i] & eclk_s3_ff[i];
                CKS_EXT_B:   base_tick[i] = eclk_s2_ff[i] ^ eclk_s3_ff[i];
                default:     base_tick[i] = 1'b0;
            endcase
        end
    end

    // cascade between channel 0 and 1, others stop on the cascade code
    always_comb begin
        tick = base_tick & {FT8_CH{!mstop_ff}};
        if (ctrl_ff[1][CTRL_CKS_LSB +: 3] == CKS_CASC) begin
            // channel 1 counts channel 0 match A events
            tick[1] = !mstop_ff && (ctrl_ff[0][CTRL_CKS_LSB +: 3] != CKS_CASC)
                      && base_tick[0] && eq_a[0];
        end
        if (ctrl_ff[0][CTRL_CKS_LSB +: 3] == CKS_CASC) begin
            // channel 0 is the upper byte, stepped by the lower byte wrapping
            tick[0] = wrap_ev[1];
        end
    end

    // ****************************************
    // per channel events
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < FT8_CH; g++) begin : g_ev
            assign eq_a[g]       = (cnt_ff[g] == cora_ff[g]);
            assign eq_b[g]       = (cnt_ff[g] == corb_ff[g]);
            assign at_top[g]     = (cnt_ff[g] == CNT_TOP);
            assign match_a_ev[g] = tick[g] && eq_a[g];
            assign match_b_ev[g] = tick[g] && eq_b[g];
            // selected clearing source
            assign clr_ev[g] =
                ((ctrl_ff[g][CTRL_CLR_LSB +: 2] == CLR_A) && match_a_ev[g]) ||
                ((ctrl_ff[g][CTRL_CLR_LSB +: 2] == CLR_B) && match_b_ev[g]) ||
                ((ctrl_ff[g][CTRL_CLR_LSB +: 2] == CLR_EXT) && !mstop_ff &&
                 erst_s2_ff[g] && !erst_s3_ff[g]);
            assign wrap_ev[g] = tick[g] && at_top[g] && !clr_ev[g];
            // requests follow flag and enable
            assign irq_a[g] = mfa_ff[g] && ctrl_ff[g][CTRL_IEA];
            assign irq_b[g] = mfb_ff[g] && ctrl_ff[g][CTRL_IEB];
            assign irq_w[g] = wrap_ff[g] && ctrl_ff[g][CTRL_IEW];
        end
    endgenerate

    // ****************************************
    // channel registers and counters
    // ****************************************
    generate
        for (g = 0; g < FT8_CH; g++) begin : g_ch
            logic wr_here;
            assign wr_here = WR_IN && acc_ok && (acc_ch == 2'(g));

            // control and output control setup
            always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
                if (!RESETN_IN) begin
                    ctrl_ff[g] <= RST_CTRL;
                    outc_ff[g] <= RST_OUTC;
                end else if (wr_here && (acc_reg == REG_CTRL)) begin
                    ctrl_ff[g] <= WDATA_IN;
                end else if (wr_here && (acc_reg == REG_OUTC)) begin
                    outc_ff[g] <= WDATA_IN;
                end
            end

            // compare constants A and B
            always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
                if (!RESETN_IN) begin
                    cora_ff[g] <= RST_COR;
                    corb_ff[g] <= RST_COR;
                end else if (wr_here && (acc_reg == REG_CORA)) begin
                    cora_ff[g] <= WDATA_IN;
                end else if (wr_here && (acc_reg == REG_CORB)) begin
                    corb_ff[g] <= WDATA_IN;
                end
            end

            // up-counter, software write wins over a count
            always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
                if (!RESETN_IN) begin
                    cnt_ff[g] <= RST_CNT;
                end else if (wr_here && (acc_reg == REG_CNT)) begin
                    cnt_ff[g] <= WDATA_IN;
                end else if (clr_ev[g]) begin
                    cnt_ff[g] <= RST_CNT;
                end else if (tick[g]) begin
                    cnt_ff[g] <= cnt_ff[g] + 8'h01;
                end
            end

            // sticky flags, a new event beats a clear in the same cycle
            always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
                if (!RESETN_IN) begin
                    mfa_ff[g]  <= 1'b0;
                    mfb_ff[g]  <= 1'b0;
                    wrap_ff[g] <= 1'b0;
                end else begin
                    if (match_a_ev[g]) begin
                        mfa_ff[g] <= 1'b1;
                    end else if (wr_here && (acc_reg == REG_STAT) && WDATA_IN[STAT_MFA]) begin
                        mfa_ff[g] <= 1'b0;
                    end
                    if (match_b_ev[g]) begin
                        mfb_ff[g] <= 1'b1;
                    end else if (wr_here && (acc_reg == REG_STAT) && WDATA_IN[STAT_MFB]) begin
                        mfb_ff[g] <= 1'b0;
                    end
                    if (wrap_ev[g]) begin
                        wrap_ff[g] <= 1'b1;
                    end else if (wr_here && (acc_reg == REG_STAT) && WDATA_IN[STAT_WRAP]) begin
                        wrap_ff[g] <= 1'b0;
                    end
                end
            end

            // output pin: action of match A, then of match B on top
            always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
                if (!RESETN_IN) begin
                    out_ff[g] <= 1'b0;
                end else begin
                    out_ff[g] <= apply_act(
                        apply_act(out_ff[g], match_a_ev[g], outc_ff[g][OUTC_A_LSB +: 2]),
                        match_b_ev[g], outc_ff[g][OUTC_B_LSB +: 2]);
                end
            end
        end
    endgenerate

    // one compare event's effect on the pin level
    function automatic logic apply_act(input logic lvl, input logic ev,
                                       input logic [1:0] act);
        logic res;
        res = lvl;
        if (ev) begin
            case (ft8_out_type'(act))
                OUT_LOW:    res = 1'b0;
                OUT_HIGH:   res = 1'b1;
                OUT_TOGGLE: res = !lvl;
                default:    res = lvl;
            endcase
        end
        return res;
    endfunction

    // ****************************************
    // read path
    // ****************************************
    always_comb begin
        nxt_rdata = 8'h00;
        if (ADDR_IN == ADDR_MSTOP) begin
            nxt_rdata = {7'h00, mstop_ff};
        end else if (acc_ok) begin
            case (acc_reg)
                REG_CTRL: nxt_rdata = ctrl_ff[acc_ch];
                REG_OUTC: nxt_rdata = outc_ff[acc_ch];
                REG_STAT: nxt_rdata = {5'h00, wrap_ff[acc_ch], mfb_ff[acc_ch], mfa_ff[acc_ch]};
                REG_CNT:  nxt_rdata = cnt_ff[acc_ch];
                REG_CORA: nxt_rdata = cora_ff[acc_ch];
                REG_CORB: nxt_rdata = corb_ff[acc_ch];
                default:  nxt_rdata = 8'h00;
            endcase
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= RD_IN ? nxt_rdata : 8'h00;
        end
    end

    // ****************************************
    // request priority
    // ****************************************
    // scan lowest to highest so the highest pending source wins
    always_comb begin
        nxt_id  = 4'h0;
        nxt_any = 1'b0;
        for (int i = FT8_CH - 1; i >= 0; i--) begin
            if (irq_w[i]) begin
                nxt_id  = 4'(3 * i + 2);
                nxt_any = 1'b1;
            end
            if (irq_b[i]) begin
                nxt_id  = 4'(3 * i + 1);
                nxt_any = 1'b1;
            end
            if (irq_a[i]) begin
                nxt_id  = 4'(3 * i);
                nxt_any = 1'b1;
            end
        end
    end

    // conversion start pulse from channel 0 match A
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            adc_ff <= 1'b0;
        end else begin
            adc_ff <= match_a_ev[0] && outc_ff[0][OUTC_ADTE];
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign RDATA_OUT       = rdata_ff;
    assign TMR_OUT_OUT     = out_ff;
    assign MATCH_A_IRQ_OUT = irq_a;
    assign MATCH_B_IRQ_OUT = irq_b;
    assign WRAP_IRQ_OUT    = irq_w;
    // only compare requests reach the transfer controller
    assign XFER_REQ_OUT    = {irq_b, irq_a};
    assign IRQ_ANY_OUT     = nxt_any;
    assign IRQ_ID_OUT      = nxt_id;
    assign ADC_TRIG_OUT    = adc_ff;
    assign MSTOP_OUT       = mstop_ff;

endmodule

// ==== ft8_timer_asserts.sv ====
`timescale 1ns/1ps
// ****************************************
// port checker of the four channel timer
// ****************************************
module ft8_timer_asserts
    import ft8_pkg::*;
(
    input wire logic                            CLK_IN,
    input wire logic                            RESETN_IN,
    input wire logic [ft8_pkg::FT8_AW-1:0]      ADDR_IN,
    input wire logic [ft8_pkg::FT8_DW-1:0]      WDATA_IN,
    input wire logic                            WR_IN,
    input wire logic                            RD_IN,
    input wire logic [ft8_pkg::FT8_DW-1:0]      RDATA_OUT,
    input wire logic [ft8_pkg::FT8_CH-1:0]      MATCH_A_IRQ_OUT,
    input wire logic [ft8_pkg::FT8_CH-1:0]      MATCH_B_IRQ_OUT,
    input wire logic [ft8_pkg::FT8_CH-1:0]      WRAP_IRQ_OUT,
    input wire logic [2*ft8_pkg::FT8_CH-1:0]    XFER_REQ_OUT,
    input wire logic                            IRQ_ANY_OUT,
    input wire logic [3:0]                      IRQ_ID_OUT,
    input wire logic                            ADC_TRIG_OUT,
    input wire logic                            MSTOP_OUT
);
    // one clock domain for every check
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESETN_IN);

    stop_write_a: assert property (WR_IN && ADDR_IN == ADDR_MSTOP |=>
        MSTOP_OUT == $past(WDATA_IN[0])) else $error("stop bit not taken");
    stop_read_a: assert property (MSTOP_OUT && RD_IN && ADDR_IN < ADDR_MSTOP |=>
        RDATA_OUT == 8'h00) else $error("read while stopped not zero");
    rdata_idle_a: assert property (!RD_IN |=> RDATA_OUT == 8'h00)
        else $error("read data outside read slot");
    irq_any_a: assert property (IRQ_ANY_OUT ==
        |{MATCH_A_IRQ_OUT, MATCH_B_IRQ_OUT, WRAP_IRQ_OUT}) else $error("summary wrong");
    xfer_req_a: assert property (XFER_REQ_OUT ==
        {MATCH_B_IRQ_OUT, MATCH_A_IRQ_OUT}) else $error("transfer request wrong");
    prio_top_a: assert property (MATCH_A_IRQ_OUT[0] |-> IRQ_ID_OUT == 4'h0)
        else $error("top priority lost");
    prio_low_a: assert property ({MATCH_A_IRQ_OUT, MATCH_B_IRQ_OUT} == 8'h00 &&
        WRAP_IRQ_OUT == 4'h8 |-> IRQ_ID_OUT == 4'hB) else $error("lowest id wrong");
    sticky_a_a: assert property (!WR_IN |=>
        ($past(MATCH_A_IRQ_OUT) & ~MATCH_A_IRQ_OUT) == 4'h0) else $error("match flag lost");
    sticky_wrap_a: assert property (!WR_IN |=>
        ($past(WRAP_IRQ_OUT) & ~WRAP_IRQ_OUT) == 4'h0) else $error("wrap flag lost");
    adc_pulse_a: assert property (ADC_TRIG_OUT |=> !ADC_TRIG_OUT)
        else $error("trigger longer than one cycle");
endmodule

// ==== ft8_ext_src.sv ====
`timescale 1ns/1ps
// ****************************************
// external count clock and reset source
// ****************************************
module ft8_ext_src (
    output logic [3:0] ext_clk_out,
    output logic [3:0] ext_rst_out
);
    // pins rest low between bursts
    initial begin
        ext_clk_out = 4'h0;
        ext_rst_out = 4'h0;
    end
    // burst of count edges, slow against the system clock
    task automatic clk_burst(input int ch, input int n);
        repeat (n) begin
            #37 ext_clk_out[ch] = 1'b1;
            #43 ext_clk_out[ch] = 1'b0;
        end
    endtask
    // one counter reset pulse
    task automatic rst_pulse(input int ch);
        #29 ext_rst_out[ch] = 1'b1;
        #61 ext_rst_out[ch] = 1'b0;
    endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
// ****************************************
// bench of the four channel timer
// ****************************************
module tb;
    import ft8_pkg::*;
    logic       CLK_IN;
    logic       RESETN_IN;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr_s;
    logic       rd_s;
    logic [7:0] rdata;
    logic [3:0] ext_clk;
    logic [3:0] ext_rst;
    logic [3:0] tmr_out;
    logic [3:0] irq_a;
    logic [3:0] irq_b;
    logic [3:0] irq_w;
    logic [7:0] xfer;
    logic       irq_any;
    logic [3:0] irq_id;
    logic       adc;
    logic       mstop;
    logic [7:0] v;
    logic [7:0] v0;
    int         mismatches;
    int         tests_run;
    int         n_adc;
    int         n_hi;

    ft8_timer u_ft8_timer (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata),
        .EXT_CLK_IN(ext_clk), .EXT_RST_IN(ext_rst), .TMR_OUT_OUT(tmr_out),
        .MATCH_A_IRQ_OUT(irq_a), .MATCH_B_IRQ_OUT(irq_b), .WRAP_IRQ_OUT(irq_w),
        .XFER_REQ_OUT(xfer), .IRQ_ANY_OUT(irq_any), .IRQ_ID_OUT(irq_id),
        .ADC_TRIG_OUT(adc), .MSTOP_OUT(mstop));
    ft8_ext_src u_ext (.ext_clk_out(ext_clk), .ext_rst_out(ext_rst));

    // system clock, 10 ns
    initial begin
        CLK_IN = 1'b0;
        forever #5 CLK_IN = ~CLK_IN;
    end

    // compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one write cycle
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge CLK_IN);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge CLK_IN);
        wr_s <= 1'b0;
        #1;
    endtask
    // one read cycle, data in the following slot
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge CLK_IN);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge CLK_IN);
        rd_s <= 1'b0;
        #1;
        d = rdata;
    endtask
    // count trigger pulses and high output cycles of channel 0
    task automatic watch(input int n);
        n_adc = 0;
        n_hi = 0;
        repeat (n) begin
            @(posedge CLK_IN);
            #1;
            n_adc += int'(adc);
            n_hi += int'(tmr_out[0]);
        end
    endtask
    // verdict and end of run
    task automatic test_done();
        $display("compares %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (5000) @(posedge CLK_IN);
        mismatches++;
        $display("BAD %0t watchdog expired", $time);
        test_done();
    end

    // main sequence
    initial begin
        mismatches = 0;
        tests_run = 0;
        RESETN_IN = 1'b0;
        addr = 6'h00;
        wdata = 8'h00;
        wr_s = 1'b0;
        rd_s = 1'b0;
        repeat (4) @(posedge CLK_IN);
        RESETN_IN <= 1'b1;
        #1;
        chk({7'h00, mstop}, 8'h01);
        wr(6'h00, 8'h29);
        rd(6'h00, v);
        chk(v, 8'h00);
        wr(ADDR_MSTOP, 8'h00);
        chk({7'h00, mstop}, 8'h00);
        rd(6'h00, v);
        chk(v, 8'h00);
        rd(6'h14, v);
        chk(v, 8'hFF);
        rd(6'h13, v);
        chk(v, 8'h00);
        rd(6'h06, v);
        chk(v, 8'h00);
        $display("test reset and stop done");
        // period 4 ticks, high from match B to match A
        wr(6'h04, 8'h03);
        wr(6'h05, 8'h01);
        wr(6'h01, 8'h19);
        wr(6'h08, 8'h07);
        wr(6'h00, 8'h69);
        repeat (64) @(posedge CLK_IN);
        watch(320);
        chk(8'(n_adc), 8'h0A);
        chk(8'(n_hi), 8'hA0);
        chk({4'h0, irq_id}, 8'h00);
        chk(xfer, 8'h11);
        chk({4'h0, irq_b}, 8'h01);
        rd(6'h02, v);
        chk(v, 8'h03);
        rd(6'h0B, v0);
        repeat (318) @(posedge CLK_IN);
        rd(6'h0B, v);
        chk(v - v0, 8'h0A);
        $display("test pulse and cascade done");
        // channel 3 wraps, lowest priority alone
        wr(6'h1B, 8'hFE);
        wr(6'h18, 8'h81);
        repeat (40) @(posedge CLK_IN);
        chk({4'h0, irq_w}, 8'h08);
        chk({4'h0, irq_id}, 8'h00);
        rd(6'h1A, v);
        chk(v, 8'h07);
        wr(6'h00, 8'h00);
        wr(6'h02, 8'h07);
        chk({4'h0, irq_id}, 8'h0B);
        chk(xfer, 8'h00);
        repeat (100) @(posedge CLK_IN);
        chk({7'h00, irq_any}, 8'h01);
        wr(6'h1A, 8'h07);
        chk({7'h00, irq_any}, 8'h00);
        $display("test wrap and priority done");
        // external count clock and external clear on channel 2
        wr(6'h10, 8'h1C);
        u_ext.clk_burst(2, 5);
        repeat (8) @(posedge CLK_IN);
        rd(6'h13, v);
        chk(v, 8'h05);
        u_ext.rst_pulse(2);
        repeat (8) @(posedge CLK_IN);
        rd(6'h13, v);
        chk(v, 8'h00);
        $display("test external pins done");
        // 16-bit mode: channel 1 low byte wraps once, channel 0 high byte steps
        wr(6'h0B, 8'hFE);
        wr(6'h03, 8'h00);
        wr(6'h00, 8'h07);
        wr(6'h08, 8'h01);
        repeat (40) @(posedge CLK_IN);
        rd(6'h03, v);
        chk(v, 8'h01);
        $display("test 16-bit count done");
        test_done();
    end
endmodule

bind ft8_timer ft8_timer_asserts u_chk (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN),
    .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .RDATA_OUT(RDATA_OUT), .MATCH_A_IRQ_OUT(MATCH_A_IRQ_OUT),
    .MATCH_B_IRQ_OUT(MATCH_B_IRQ_OUT), .WRAP_IRQ_OUT(WRAP_IRQ_OUT),
    .XFER_REQ_OUT(XFER_REQ_OUT), .IRQ_ANY_OUT(IRQ_ANY_OUT), .IRQ_ID_OUT(IRQ_ID_OUT),
    .ADC_TRIG_OUT(ADC_TRIG_OUT), .MSTOP_OUT(MSTOP_OUT));
